//--- hsp_consts.vh
`ifndef HSP_CONSTS_VH
`define HSP_CONSTS_VH
`define HSP_MODE_DIRECT 2'h0
`define HSP_MODE_FIFO 2'h1
`define HSP_MODE_STORED 2'h2
`define HSP_PIN_READY 3'h7
`define HSP_BC_STATUS 5'h0c
`define HSP_CMD_BLOCK_WRITE 16'h0014
`define HSP_CMD_PLAY 16'h0013
`define HSP_WORD_W 16
`define HSP_SAMPLE_W 12
`define HSP_RAM_DEPTH 1024
`define HSP_RAM_AW 10
`define HSP_BUF_DEPTH 8
`define HSP_BUF_AW 3
`define HSP_CLK_NS 20
`define HSP_GAP_NS 4000
`define HSP_GAP_CYCLES (`HSP_GAP_NS / `HSP_CLK_NS)
`define HSP_RATE_BASE 16'h0008
`define HSP_RAMP_STEP 12'h010
`define HSP_ST_CMD 3'h0
`define HSP_ST_WADDR 3'h1
`define HSP_ST_WCNT 3'h2
`define HSP_ST_WDATA 3'h3
`define HSP_ST_PSTART 3'h4
`define HSP_ST_PEND 3'h5
`endif

//--- hsp_playback.v
`include "hsp_consts.vh"

module hsp_buf #(
  parameter W = 17,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp, rp;
  reg [AW:0] cnt;
  wire push, pop;
  assign in_ready = (cnt != D[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // hsp_buf

module hsp_playback #(
  parameter [15:0] RATE_BASE = `HSP_RATE_BASE,
  parameter [11:0] RAMP_STEP = `HSP_RAMP_STEP
) (
  input wire clk,
  input wire rst,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe_n,
  input wire [1:0] mode,
  input wire [2:0] play_rate,
  input wire output_enable,
  input wire [2:0] output_pin_function_select,
  input wire interpreter_route_bit,
  input wire [4:0] readback_select_field,
  output reg [11:0] sample_out,
  output reg sample_strobe,
  output reg general_output_pin,
  output reg fifo_empty,
  output reg fifo_full,
  output reg [9:0] fifo_free_space,
  output wire word_ready,
  output reg interp_active
);
  reg [2:0] cs_s, sck_s, sdi_s;
  reg cs_f, sck_f, sdi_f, cs_prev, sck_prev;
  reg [14:0] rx;
  reg [3:0] bit_cnt;
  reg [15:0] tx, word, rate_cnt;
  reg load_pend, word_valid, word_route, route_prev;
  reg [7:0] gap_cnt;
  reg [2:0] state;
  reg [9:0] wr_addr, wp, rp, play_addr, play_end;
  reg [10:0] wr_left, cnt;
  reg play_armed, stored_done, phase, tick;
  reg [15:0] ram [0:`HSP_RAM_DEPTH-1];
  wire b_valid, pop, is_route, fifo_has_room, push_fifo, ram_we;
  wire [16:0] b_data;
  wire [15:0] w, rate_lim, status_word;
  wire [9:0] ram_wa;
  wire [11:0] cur, nxt;
  wire [12:0] mid_sum;
  wire [10:0] free_full;

  // Serial link sampled by clk
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      cs_f <= 1'b1;
      sck_f <= 1'b0;
      sdi_f <= 1'b0;
      cs_prev <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_s <= {cs_s[1:0], spi_cs_n};
      sck_s <= {sck_s[1:0], spi_sclk};
      sdi_s <= {sdi_s[1:0], spi_sdi};
      if (cs_s[1] == cs_s[2]) begin
        cs_f <= cs_s[2];
      end
      if (sck_s[1] == sck_s[2]) begin
        sck_f <= sck_s[2];
      end
      if (sdi_s[1] == sdi_s[2]) begin
        sdi_f <= sdi_s[2];
      end
      cs_prev <= cs_f;
      sck_prev <= sck_f;
    end
  end

  assign status_word = (readback_select_field == `HSP_BC_STATUS) ?
    {12'h000, stored_done, play_armed, fifo_full, fifo_empty} :
    {6'h00, fifo_free_space};
  assign spi_sdo = tx[15];
  assign spi_sdo_oe_n = cs_f;

  // 16-bit frames, MSB first, burst under held select
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx <= 15'h0000;
      bit_cnt <= 4'h0;
      tx <= 16'h0000;
      load_pend <= 1'b0;
      word_valid <= 1'b0;
      word <= 16'h0000;
      word_route <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (cs_f) begin
        bit_cnt <= 4'h0;
        load_pend <= 1'b0;
      end else begin
        if (cs_prev) begin
          tx <= status_word;
        end
        if (sck_f && !sck_prev) begin
          rx <= {rx[13:0], sdi_f};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf) begin
            word_valid <= 1'b1;
            word <= {rx, sdi_f};
            word_route <= interp_active;
            load_pend <= 1'b1;
          end
        end
        if (!sck_f && sck_prev) begin
          if (load_pend) begin
            tx <= status_word;
            load_pend <= 1'b0;
          end else begin
            tx <= {tx[14:0], 1'b0};
          end
        end
      end
    end
  end

  hsp_buf #(
    .W(17),
    .D(`HSP_BUF_DEPTH),
    .AW(`HSP_BUF_AW)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data({word_route, word}),
    .out_valid(b_valid),
    .out_ready(!tick),
    .out_data(b_data)
  );

  assign pop = b_valid && !tick;
  assign w = b_data[15:0];
  assign is_route = b_data[16];

  // Interpreter access window
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      route_prev <= 1'b0;
      gap_cnt <= 8'h00;
      interp_active <= 1'b0;
    end else begin
      route_prev <= interpreter_route_bit;
      if (word_valid || !interp_active) begin
        gap_cnt <= 8'h00;
      end else begin
        gap_cnt <= gap_cnt + 8'h01;
      end
      if (interpreter_route_bit && !route_prev) begin
        interp_active <= 1'b1;
      end else if (interp_active && !word_valid &&
                   gap_cnt == `HSP_GAP_CYCLES - 1) begin
        interp_active <= 1'b0;
      end
    end
  end

  // Readout rate divider
  assign rate_lim = RATE_BASE << play_rate;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (rate_cnt >= rate_lim - 16'h0001) begin
        rate_cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        rate_cnt <= rate_cnt + 16'h0001;
      end
    end
  end

  // Single write port for waveform RAM
  assign fifo_has_room = (cnt != 11'd`HSP_RAM_DEPTH);
  assign push_fifo = pop && !is_route && mode == `HSP_MODE_FIFO &&
    fifo_has_room;
  assign ram_we = push_fifo ||
    (pop && is_route && state == `HSP_ST_WDATA);
  assign ram_wa = push_fifo ? wp : wr_addr;
  always @(posedge clk) begin
    if (ram_we) begin
      ram[ram_wa] <= w;
    end
  end

  assign cur = ram[play_addr][11:0];
  assign nxt = ram[play_addr + 10'h001][11:0];
  assign mid_sum = {1'b0, cur} + {1'b0, nxt};
  assign free_full = 11'd`HSP_RAM_DEPTH - cnt;

  // Interpreter, queue and playback
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= `HSP_ST_CMD;
      wr_addr <= 10'h000;
      wr_left <= 11'h000;
      wp <= 10'h000;
      rp <= 10'h000;
      cnt <= 11'h000;
      play_addr <= 10'h000;
      play_end <= 10'h000;
      play_armed <= 1'b0;
      stored_done <= 1'b0;
      phase <= 1'b0;
      sample_out <= 12'h000;
      sample_strobe <= 1'b0;
      general_output_pin <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      general_output_pin <= 1'b0;
      if (!interp_active) begin
        state <= `HSP_ST_CMD;
      end else if (pop && is_route) begin
        case (state)
          `HSP_ST_CMD: begin
            if (w == `HSP_CMD_BLOCK_WRITE) begin
              state <= `HSP_ST_WADDR;
            end else if (w == `HSP_CMD_PLAY) begin
              state <= `HSP_ST_PSTART;
            end
          end
          `HSP_ST_WADDR: begin
            wr_addr <= w[9:0];
            state <= `HSP_ST_WCNT;
          end
          `HSP_ST_WCNT: begin
            wr_left <= w[10:0];
            state <= (w[10:0] == 11'h000) ? `HSP_ST_CMD : `HSP_ST_WDATA;
          end
          `HSP_ST_WDATA: begin
            wr_addr <= wr_addr + 10'h001;
            wr_left <= wr_left - 11'h001;
            if (wr_left == 11'h001) begin
              state <= `HSP_ST_CMD;
            end
          end
          `HSP_ST_PSTART: begin
            play_addr <= w[9:0];
            state <= `HSP_ST_PEND;
          end
          `HSP_ST_PEND: begin
            play_end <= w[9:0];
            play_armed <= 1'b1;
            stored_done <= 1'b0;
            phase <= 1'b0;
            state <= `HSP_ST_CMD;
          end
          default: begin
            state <= `HSP_ST_CMD;
          end
        endcase
      end
      if (push_fifo) begin
        wp <= wp + 10'h001;
        cnt <= cnt + 11'h001;
      end
      if (pop && !is_route && mode == `HSP_MODE_DIRECT) begin
        sample_out <= w[11:0];
        sample_strobe <= 1'b1;
      end else if (tick) begin
        if (mode == `HSP_MODE_DIRECT &&
            output_pin_function_select == `HSP_PIN_READY) begin
          general_output_pin <= 1'b1;
        end
        if (!output_enable) begin
          if (sample_out != 12'h000) begin
            sample_strobe <= 1'b1;
            sample_out <= (sample_out > RAMP_STEP) ?
              sample_out - RAMP_STEP : 12'h000;
          end
        end else if (mode == `HSP_MODE_FIFO) begin
          if (cnt != 11'h000) begin
            sample_out <= ram[rp][11:0];
            sample_strobe <= 1'b1;
            rp <= rp + 10'h001;
            cnt <= cnt - 11'h001;
          end
        end else if (mode == `HSP_MODE_STORED) begin
          if (play_armed && !stored_done) begin
            sample_strobe <= 1'b1;
            if (phase) begin
              sample_out <= mid_sum[12:1];
              phase <= 1'b0;
              play_addr <= play_addr + 10'h001;
            end else begin
              sample_out <= cur;
              if (play_addr == play_end) begin
                stored_done <= 1'b1;
                play_armed <= 1'b0;
              end else if (play_rate != 3'h0) begin
                phase <= 1'b1;
              end else begin
                play_addr <= play_addr + 10'h001;
              end
            end
          end
        end
      end
    end
  end

  // Registered status flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
      fifo_free_space <= 10'h3ff;
    end else begin
      fifo_empty <= (mode == `HSP_MODE_STORED) ? stored_done :
        (cnt == 11'h000);
      fifo_full <= !fifo_has_room;
      fifo_free_space <= free_full[10] ? 10'h3ff : free_full[9:0];
    end
  end
endmodule // hsp_playback

//--- hsp_playback_assertions.sv
module hsp_playback_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe_n,
  input wire logic [1:0] mode,
  input wire logic output_enable,
  input wire logic [2:0] output_pin_function_select,
  input wire logic [11:0] sample_out,
  input wire logic general_output_pin,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic [9:0] fifo_free_space
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_direct;
    mode == 2'h0 ##1 mode == 2'h0;
  endsequence
  sequence s_parked;
    mode == 2'h1 && !output_enable ##1 mode == 2'h1 && !output_enable;
  endsequence
  sequence s_dry;
    (mode == 2'h1 && output_enable && fifo_empty) [*4];
  endsequence
  property p_cs_idle;
    spi_cs_n [*5] |-> spi_sdo_oe_n;
  endproperty
  property p_pin_cause;
    general_output_pin |-> $past(mode) == 2'h0
      && $past(output_pin_function_select) == 3'h7;
  endproperty
  property p_pin_pulse;
    general_output_pin |=> !general_output_pin;
  endproperty
  property p_direct_noram;
    s_direct |-> $stable(fifo_free_space);
  endproperty
  property p_flags;
    !(fifo_full && fifo_empty);
  endproperty
  property p_empty_free;
    mode == 2'h1 && fifo_empty |-> fifo_free_space == 10'h3ff;
  endproperty
  property p_hold;
    s_dry |-> $stable(sample_out);
  endproperty
  property p_ramp;
    s_parked |-> sample_out <= $past(sample_out);
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("sdo driven idle");
  a_pin_cause: assert property (p_pin_cause)
    else $error("stray pin pulse");
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("pin pulse too long");
  a_direct_noram: assert property (p_direct_noram)
    else $error("direct mode queued");
  a_flags: assert property (p_flags)
    else $error("full and empty");
  a_empty_free: assert property (p_empty_free)
    else $error("free space wrong");
  a_hold: assert property (p_hold)
    else $error("output moved when empty");
  a_ramp: assert property (p_ramp)
    else $error("output rose while disabled");
endmodule // hsp_playback_assertions

//--- hsp_host_model.sv
module hsp_host_model (
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // One word MSB first, data moved on sclk fall, clock idle low
  task automatic word(input logic [15:0] w, input bit hold);
    if (cs_n) begin
      #3 cs_n = 1'b0;
      #80;
    end
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #80 sclk = 1'b1;
      #80 rx[i] = sdo;
      sclk = 1'b0;
    end
    if (!hold) begin
      #80 cs_n = 1'b1;
      sdi = ~sdi;
    end
  endtask
endmodule // hsp_host_model

//--- hsp_playback_test.sv
module hsp_playback_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RB = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [2:0] play_rate = 3'h0;
  logic output_enable = 1'b0;
  logic [2:0] output_pin_function_select = 3'h0;
  logic interpreter_route_bit = 1'b0;
  logic [4:0] readback_select_field = 5'h00;
  wire spi_cs_n;
  wire spi_sclk;
  wire spi_sdi;
  wire spi_sdo;
  wire spi_sdo_oe_n;
  wire [11:0] sample_out;
  wire sample_strobe;
  wire general_output_pin;
  wire fifo_empty;
  wire fifo_full;
  wire [9:0] fifo_free_space;
  wire interp_active;
  wire word_ready;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  hsp_playback #(.RATE_BASE(16'(RB))) u_dut (.*);
  hsp_host_model u_host (.cs_n(spi_cs_n), .sclk(spi_sclk),
    .sdi(spi_sdi), .sdo(spi_sdo_oe_n ? ~spi_sdo : spi_sdo));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] w[$]);
    foreach (w[i]) u_host.word(w[i], i < w.size() - 1);
    repeat (4) @(negedge clk);
  endtask
  task automatic grab(output logic [11:0] v);
    int n;
    n = 0;
    while (sample_strobe !== 1'b1 && n < 1500) begin
      @(negedge clk);
      n++;
    end
    v = sample_out;
    @(negedge clk);
  endtask
  task automatic play_chk(input logic [11:0] e[$]);
    logic [11:0] v;
    foreach (e[i]) begin
      grab(v);
      chk(16'(v), 16'(e[i]), "sample");
    end
  endtask
  task automatic gap(output int t);
    int n;
    n = 0;
    while (general_output_pin !== 1'b1 && n < 1500) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    t = 1;
    while (general_output_pin !== 1'b1 && t < 1500) begin
      @(negedge clk);
      t++;
    end
  endtask
  task automatic t_reset();
    chk(16'(fifo_empty), 16'h0001, "empty");
    chk(16'(fifo_free_space), 16'h03ff, "free");
    chk(16'(spi_sdo_oe_n), 16'h0001, "oe_n");
    chk(16'(fifo_full), 16'h0000, "full");
    chk(16'(word_ready), 16'h0001, "wready");
    $display("test reset done");
  endtask
  task automatic t_direct();
    logic [11:0] v;
    int t;
    output_enable = 1'b1;
    output_pin_function_select = 3'h7;
    fork
      send('{16'hf012});
      grab(v);
    join
    chk(16'(v), 16'h0012, "direct");
    chk(16'(fifo_free_space), 16'h03ff, "ram");
    for (int i = 0; i < 8; i++) begin
      play_rate = 3'(i);
      gap(t);
      gap(t);
      chk(16'(t), 16'(RB << i), "rate");
    end
    output_pin_function_select = 3'h0;
    $display("test direct done");
  endtask
  task automatic t_fifo();
    mode = 2'h1;
    output_enable = 1'b0;
    play_rate = 3'h0;
    send('{16'h0000});
    chk(u_host.rx, 16'h03ff, "space");
    send('{16'h0066, 16'h00cc, 16'h0132, 16'h0198});
    chk(16'(fifo_free_space), 16'd1019, "count");
    chk(16'(fifo_full), 16'h0000, "notfull");
    chk(16'(word_ready), 16'h0001, "drained");
    output_enable = 1'b1;
    play_chk('{12'h000, 12'h066, 12'h0cc, 12'h132, 12'h198});
    repeat (40) @(negedge clk);
    chk(16'(fifo_empty), 16'h0001, "empty");
    chk(16'(sample_out), 16'h0198, "held");
    output_enable = 1'b0;
    send('{16'h0300, 16'h0200, 16'h0100});
    output_enable = 1'b1;
    play_chk('{12'h300});
    output_enable = 1'b0;
    repeat (RB * 48 + 40) @(negedge clk);
    chk(16'(sample_out), 16'h0000, "ramp");
    chk(16'(fifo_free_space), 16'd1022, "kept");
    output_enable = 1'b1;
    play_chk('{12'h200, 12'h100});
    $display("test fifo done");
  endtask
  task automatic t_stored();
    output_enable = 1'b0;
    mode = 2'h2;
    interpreter_route_bit = 1'b1;
    send('{16'h0014, 16'h0000, 16'h0004, 16'h0000, 16'h0100, 16'h0200,
      16'h0080, 16'h0013, 16'h0000, 16'h0003});
    interpreter_route_bit = 1'b0;
    chk(16'(interp_active), 16'h0001, "open");
    repeat (210) @(negedge clk);
    chk(16'(interp_active), 16'h0000, "closed");
    output_enable = 1'b1;
    play_chk('{12'h000, 12'h100, 12'h200, 12'h080});
    repeat (20) @(negedge clk);
    chk(16'(fifo_empty), 16'h0001, "done");
    output_enable = 1'b0;
    mode = 2'h0;
    send('{16'h0000});
    mode = 2'h2;
    interpreter_route_bit = 1'b1;
    send('{16'h0013, 16'h0000, 16'h0003});
    interpreter_route_bit = 1'b0;
    repeat (210) @(negedge clk);
    play_rate = 3'h1;
    output_enable = 1'b1;
    play_chk('{12'h000, 12'h080, 12'h100, 12'h180, 12'h200, 12'h140,
      12'h080});
    repeat (20) @(negedge clk);
    readback_select_field = 5'h0c;
    send('{16'h0000});
    chk(16'(u_host.rx[0]), 16'h0001, "status");
    $display("test stored done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_direct();
    t_fifo();
    t_stored();
    summarize();
  end
endmodule // hsp_playback_test

bind hsp_playback hsp_playback_assertions u_chk (.*);
